// ---- hw/monitor_alarm_resistor_control.sv ----
// Operation
// RL1 - Low protect pin always allows writes
// RL2 - Disable pin high opens both resistors
// RL3 - Each conversion sets its channel done bit
// RL4 - Results compared against high and low limits
// RL5 - Separate high and low alarm flags
// RL6 - Per-channel interrupt enable on alarms
// RL7 - Resistor position from 2 degree table
// RL8 - Two resistors programmed independently
// RL9 - Two open-drain buffers follow inputs
// RL10 - Alarm can assert buffer A output
// RL11 - Results are 16-bit, 12 bits left-justified
// RL12 - Software masks the four low bits
// RL13 - Channels refreshed in fixed rotation
// RL14 - Temperature result is two's complement
// RL15 - Supply and inputs are unsigned
// RL16 - Supply count weighs 100 microvolts
// RL17 - Input count weighs 38.147 microvolts
// RL18 - Frame typically 20 ms, at most 30
// RL19 - Temperature high byte degrees, low fraction
// RL20 - Buffers non-inverting: low in pulls low
// RL21 - Buffer A active on input or alarm
// RL22 - Flags stay set until software clears
//
// Added by the designer: the APB register port and the register offsets.
`include "monitor_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module monitor_alarm_resistor_control
    import monitor_pkg::*;
#(
    parameter int SLOT_CYCLES = `SLOT_CYCLES
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter front end
    output logic conv_start,
    output logic [1:0] conv_channel,
    input wire logic conv_done,
    input wire logic [11:0] conv_code,
    // Pins
    input wire logic write_protect_pin,
    input wire logic resistor_disable_pin,
    input wire logic buffer_a_input,
    input wire logic buffer_b_input,
    output logic buffer_a_output_oe,
    output logic buffer_b_output_oe,
    // Resistor control
    output logic [7:0] resistor_zero_position,
    output logic [7:0] resistor_one_position,
    output logic resistors_connected,
    output logic alarm_interrupt
);

    // ==========================================================
    // Pin synchronisers
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta <= 4'hF;
            pin_sync <= 4'hF;
        end
        else
        begin
            pin_meta <= {buffer_b_input, buffer_a_input, resistor_disable_pin,
                         write_protect_pin};
            pin_sync <= pin_meta;
        end
    end

    logic wp_level;
    logic disable_level;
    logic in_a_level;
    logic in_b_level;
    assign wp_level = pin_sync[0];
    assign disable_level = pin_sync[1];
    assign in_a_level = pin_sync[2];
    assign in_b_level = pin_sync[3];

    // ==========================================================
    // Registers
    logic [2:0] control;
    logic [3:0] done_flags;
    logic [3:0] alarm_high;
    logic [3:0] alarm_low;
    logic [3:0] int_enable;
    logic [15:0] manual_pos;
    logic [15:0] result [4];
    logic [15:0] high_limit [4];
    logic [15:0] low_limit [4];
    logic [7:0] lut_zero [`LUT_ENTRIES];
    logic [7:0] lut_one [`LUT_ENTRIES];
    logic [6:0] temp_index;

    logic protected_now;
    assign protected_now = wp_level && control[`CTRL_PROTECT_BIT]; // RL1

    logic setup_phase;
    logic wr_commit;
    assign setup_phase = psel && !penable;
    assign wr_commit = psel && penable && pready && pwrite;

    // Address classification
    logic [1:0] word_sel;
    logic [6:0] lut_sel;
    logic is_lut;
    logic is_prot_reg;
    logic is_mapped;
    logic [11:0] lut_off;
    assign word_sel = paddr[3:2];
    // Table runs past 0x1FF, so index from the offset, not raw address bits
    assign lut_off = paddr - `OFS_LUT_BASE;
    assign lut_sel = lut_off[8:2];
    assign is_lut = (paddr >= `OFS_LUT_BASE) && (lut_off[1:0] == 2'h0)
                    && (lut_off[11:2] < 10'(`LUT_ENTRIES));

    always_comb
    begin
        is_mapped = 1'b1;
        is_prot_reg = 1'b0;
        if (is_lut)
            is_prot_reg = 1'b1;
        else if (paddr == `OFS_CONTROL || paddr == `OFS_MANUAL_POS
                 || paddr == `OFS_INT_ENABLE)
            is_prot_reg = 1'b1;
        else if ((paddr & 12'hFF3) == `OFS_HIGH_BASE || (paddr & 12'hFF3) == `OFS_LOW_BASE)
            is_prot_reg = 1'b1;
        else if (paddr == `OFS_STATUS || paddr == `OFS_DONE_FLAGS
                 || paddr == `OFS_ALARM_HIGH || paddr == `OFS_ALARM_LOW
                 || paddr == `OFS_INDEX_STATE || (paddr & 12'hFF3) == `OFS_RESULT_BASE)
            is_mapped = 1'b1;
        else
            is_mapped = 1'b0;
    end

    logic wr_ok;
    assign wr_ok = wr_commit && is_mapped && !(is_prot_reg && protected_now);

    // ==========================================================
    // APB answer: one wait-free access phase, data captured in setup
    logic [31:0] next_prdata;

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (is_lut)
            next_prdata = {16'h0000, lut_one[lut_sel], lut_zero[lut_sel]};
        else if (paddr == `OFS_CONTROL)
            next_prdata = {29'h0, control};
        else if (paddr == `OFS_STATUS)
            next_prdata = {28'h0, disable_level, wp_level, protected_now, alarm_interrupt};
        else if (paddr == `OFS_DONE_FLAGS)
            next_prdata = {28'h0, done_flags};
        else if (paddr == `OFS_ALARM_HIGH)
            next_prdata = {28'h0, alarm_high};
        else if (paddr == `OFS_ALARM_LOW)
            next_prdata = {28'h0, alarm_low};
        else if (paddr == `OFS_INT_ENABLE)
            next_prdata = {28'h0, int_enable};
        else if (paddr == `OFS_MANUAL_POS)
            next_prdata = {16'h0, manual_pos};
        else if (paddr == `OFS_INDEX_STATE)
            next_prdata = {9'h0, temp_index, resistor_one_position, resistor_zero_position};
        else if ((paddr & 12'hFF3) == `OFS_RESULT_BASE)
            next_prdata = {16'h0, result[word_sel]}; // RL11
        else if ((paddr & 12'hFF3) == `OFS_HIGH_BASE)
            next_prdata = {16'h0, high_limit[word_sel]};
        else if ((paddr & 12'hFF3) == `OFS_LOW_BASE)
            next_prdata = {16'h0, low_limit[word_sel]};
        else
            next_prdata = 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup_phase;
            if (setup_phase)
            begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= !is_mapped || (pwrite && is_prot_reg && protected_now);
            end
        end
    end

    // Configuration writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control <= `CTRL_RESET;
            int_enable <= 4'h0;
            manual_pos <= 16'h0000;
            for (int i = 0; i < 4; i++)
            begin
                high_limit[i] <= 16'hFFFF;
                low_limit[i] <= 16'h0000;
            end
        end
        else if (wr_ok)
        begin
            if (paddr == `OFS_CONTROL)
                control <= pwdata[2:0];
            else if (paddr == `OFS_INT_ENABLE)
                int_enable <= pwdata[3:0]; // RL6
            else if (paddr == `OFS_MANUAL_POS)
                manual_pos <= pwdata[15:0]; // RL8
            else if ((paddr & 12'hFF3) == `OFS_HIGH_BASE)
                high_limit[word_sel] <= pwdata[15:0];
            else if ((paddr & 12'hFF3) == `OFS_LOW_BASE)
                low_limit[word_sel] <= pwdata[15:0];
        end
    end

    // Table holds no reset; contents are software's to load
    always_ff @(posedge pclk)
    begin
        if (wr_ok && is_lut)
        begin
            lut_zero[lut_sel] <= pwdata[7:0]; // RL8
            lut_one[lut_sel] <= pwdata[15:8];
        end
    end

    // ==========================================================
    // Conversion rotation
    seq_state_t seq_state;
    logic [31:0] slot_count;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq_state <= SEQ_WAIT;
            slot_count <= 32'h0000_0000;
            conv_start <= 1'b0;
            conv_channel <= 2'h0;
        end
        else
        begin
            conv_start <= 1'b0;
            slot_count <= (slot_count == 32'(SLOT_CYCLES - 1)) ? 32'h0 : slot_count + 32'h1;
            case (seq_state)
                SEQ_WAIT:
                    if (slot_count == 32'(SLOT_CYCLES - 1))
                    begin
                        conv_start <= 1'b1;
                        seq_state <= SEQ_CONVERT;
                    end
                SEQ_CONVERT:
                    if (conv_done)
                    begin
                        conv_channel <= conv_channel + 2'h1; // RL13 RL18
                        seq_state <= SEQ_WAIT;
                    end
                default:
                    seq_state <= SEQ_WAIT;
            endcase
        end
    end

    logic conv_take;
    logic [15:0] new_result;
    assign conv_take = (seq_state == SEQ_CONVERT) && conv_done;
    assign new_result = {conv_code, 4'h0}; // RL11 RL14 RL15 RL16 RL17 RL19

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
                result[i] <= 16'h0000;
        end
        else if (conv_take)
            result[conv_channel] <= new_result;
    end

    // ==========================================================
    // Limit checks; temperature compares signed
    logic above;
    logic below;

    always_comb
    begin
        if (conv_channel == CH_TEMP)
        begin
            above = $signed(new_result) > $signed(high_limit[conv_channel]); // RL14
            below = $signed(new_result) < $signed(low_limit[conv_channel]);
        end
        else
        begin
            above = new_result > high_limit[conv_channel]; // RL15
            below = new_result < low_limit[conv_channel];
        end
    end

    logic clr_done;
    logic clr_high;
    logic clr_low;
    assign clr_done = wr_ok && paddr == `OFS_DONE_FLAGS;
    assign clr_high = wr_ok && paddr == `OFS_ALARM_HIGH;
    assign clr_low = wr_ok && paddr == `OFS_ALARM_LOW;

    // Write one to clear; a same-cycle set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_flags <= 4'h0;
            alarm_high <= 4'h0;
            alarm_low <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (conv_take && conv_channel == 2'(i))
                    done_flags[i] <= 1'b1; // RL3
                else if (clr_done && pwdata[i])
                    done_flags[i] <= 1'b0; // RL22
                if (conv_take && conv_channel == 2'(i) && above)
                    alarm_high[i] <= 1'b1; // RL4 RL5
                else if (clr_high && pwdata[i])
                    alarm_high[i] <= 1'b0; // RL22
                if (conv_take && conv_channel == 2'(i) && below)
                    alarm_low[i] <= 1'b1; // RL4 RL5
                else if (clr_low && pwdata[i])
                    alarm_low[i] <= 1'b0;
            end
        end
    end

    logic [3:0] enabled_alarms;
    assign enabled_alarms = (alarm_high | alarm_low) & int_enable;

    // ==========================================================
    // Resistor positions and outputs
    logic signed [8:0] shifted_deg;
    logic [6:0] next_index;
    assign shifted_deg = $signed({result[CH_TEMP][15], result[CH_TEMP][15:8]})
                         + $signed(`LUT_OFFSET_DEG);

    always_comb
    begin
        if (shifted_deg < 0)
            next_index = 7'h00;
        else if (shifted_deg[8:1] > {1'b0, `LUT_LAST})
            next_index = `LUT_LAST;
        else
            next_index = shifted_deg[7:1]; // RL7
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            temp_index <= 7'h00;
            resistor_zero_position <= 8'h00;
            resistor_one_position <= 8'h00;
            resistors_connected <= 1'b0;
            buffer_a_output_oe <= 1'b0;
            buffer_b_output_oe <= 1'b0;
            alarm_interrupt <= 1'b0;
        end
        else
        begin
            temp_index <= next_index;
            if (control[`CTRL_TEMP_INDEX_BIT])
            begin
                resistor_zero_position <= lut_zero[temp_index]; // RL7 RL8
                resistor_one_position <= lut_one[temp_index];
            end
            else
            begin
                resistor_zero_position <= manual_pos[7:0];
                resistor_one_position <= manual_pos[15:8];
            end
            resistors_connected <= !disable_level; // RL2
            buffer_a_output_oe <= !in_a_level
                || (control[`CTRL_ALARM_TO_BUF_BIT] && |(alarm_high | alarm_low)); // RL9 RL10 RL20 RL21
            buffer_b_output_oe <= !in_b_level; // RL9 RL20
            alarm_interrupt <= |enabled_alarms; // RL6
        end
    end

    // ==========================================================
    // Checks
    sequence seq_conv_done_ch(int ch);
        conv_take && conv_channel == 2'(ch);
    endsequence

    AST_DONE_SET: assert property (@(posedge pclk) disable iff (!presetn) // RL3
        seq_conv_done_ch(0) |=> done_flags[0])
        else $error("done flag not set after conversion");
    AST_HIGH_ALARM: assert property (@(posedge pclk) disable iff (!presetn) // RL4
        conv_take && above |=> alarm_high[$past(conv_channel)])
        else $error("high alarm not set");
    AST_LOW_ALARM: assert property (@(posedge pclk) disable iff (!presetn) // RL5
        conv_take && below |=> alarm_low[$past(conv_channel)])
        else $error("low alarm not set");
    AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn) // RL22
        alarm_high[1] && !(clr_high && pwdata[1]) |=> alarm_high[1])
        else $error("alarm cleared by itself");
    AST_DISABLE: assert property (@(posedge pclk) disable iff (!presetn) // RL2
        disable_level |=> !resistors_connected)
        else $error("resistors connected while disabled");
    AST_WP_LOW: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        !wp_level |-> !protected_now)
        else $error("protected while pin low");
    AST_BUF_B: assert property (@(posedge pclk) disable iff (!presetn) // RL20
        !in_b_level |=> buffer_b_output_oe)
        else $error("buffer b not pulling low");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        (|enabled_alarms) |=> alarm_interrupt)
        else $error("interrupt not raised");
    AST_ROTATE: assert property (@(posedge pclk) disable iff (!presetn) // RL13
        conv_take |=> conv_channel == $past(conv_channel) + 2'h1)
        else $error("rotation out of order");
    AST_LEFT_JUST: assert property (@(posedge pclk) disable iff (!presetn) // RL11
        conv_take |=> result[$past(conv_channel)][3:0] == 4'h0)
        else $error("result not left-justified");

endmodule

`default_nettype wire

// ---- hw/monitor_regs.svh ----
`ifndef MONITOR_REGS_SVH
`define MONITOR_REGS_SVH

// Register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_DONE_FLAGS 12'h008
`define OFS_ALARM_HIGH 12'h00C
`define OFS_ALARM_LOW 12'h010
`define OFS_INT_ENABLE 12'h014
`define OFS_MANUAL_POS 12'h018
`define OFS_INDEX_STATE 12'h01C
`define OFS_RESULT_BASE 12'h020
`define OFS_HIGH_BASE 12'h030
`define OFS_LOW_BASE 12'h040
`define OFS_LUT_BASE 12'h100

// Control fields and reset value
`define CTRL_TEMP_INDEX_BIT 0
`define CTRL_PROTECT_BIT 1
`define CTRL_ALARM_TO_BUF_BIT 2
`define CTRL_RESET 3'h1

// Temperature table: 72 steps of 2 degrees from -40
`define LUT_ENTRIES 72
`define LUT_LAST 7'h47
`define LUT_OFFSET_DEG 9'h028

// Frame timing
`define FRAME_TIME_MS 20
`define FRAME_MAX_MS 30
`define CLK_MHZ 50
`define CHANNELS 4
`define SLOT_CYCLES (`FRAME_TIME_MS * 1000 * `CLK_MHZ / `CHANNELS)
`define FRAME_MAX_CYCLES (`FRAME_MAX_MS * 1000 * `CLK_MHZ)

`endif

// ---- hw/monitor_pkg.sv ----
package monitor_pkg;

    typedef enum logic [0:0] {SEQ_WAIT, SEQ_CONVERT} seq_state_t;

    // Channel order in the rotation
    typedef enum logic [1:0] {CH_TEMP, CH_SUPPLY, CH_INPUT_A, CH_INPUT_B} channel_t;

endpackage

// ---- testbench/conv_front_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Converter front end model
module conv_front_model
#(
    parameter int FAST = 2,
    parameter int SLOW = 12
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Conversion handshake
    input wire logic conv_start,
    input wire logic [1:0] conv_channel,
    output logic conv_done,
    output logic [11:0] conv_code,
    // Scenario control
    input wire logic slow,
    input wire logic [47:0] codes
);
    logic busy;
    logic [1:0] ch;
    int cnt;

    // Code toggles outside the done cycle, so a late sample sees junk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            ch <= 2'h0;
            cnt <= 0;
            conv_done <= 1'b0;
            conv_code <= 12'hA5A;
        end
        else
        begin
            conv_done <= 1'b0;
            conv_code <= ~conv_code;
            if (conv_start)
            begin
                busy <= 1'b1;
                ch <= conv_channel;
                cnt <= slow ? SLOW : FAST;
            end
            else if (busy && cnt > 1)
                cnt <= cnt - 1;
            else if (busy)
            begin
                busy <= 1'b0;
                conv_done <= 1'b1;
                conv_code <= codes[ch*12 +: 12];
            end
        end
    end
endmodule

`default_nettype wire

// ---- testbench/test_monitor_alarm_resistor_control.sv ----
`include "monitor_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module test_monitor_alarm_resistor_control;
    // ==========================================
    // Signals and instances
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, conv_start, conv_done, oe_a, oe_b, connected, irq;
    logic [1:0] conv_channel;
    logic [11:0] conv_code;
    logic [7:0] pos0, pos1;
    logic wp = 1'b1;
    logic dis = 1'b1;
    logic in_a = 1'b1;
    logic in_b = 1'b1;
    logic slow = 1'b0;
    logic [47:0] codes = 48'h0;
    logic [1:0] exp_ch;
    int n_fail = 0;
    int n_compared = 0;

    always #10 pclk = ~pclk;

    monitor_alarm_resistor_control #(.SLOT_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done), .conv_code(conv_code),
        .write_protect_pin(wp), .resistor_disable_pin(dis), .buffer_a_input(in_a),
        .buffer_b_input(in_b), .buffer_a_output_oe(oe_a), .buffer_b_output_oe(oe_b),
        .resistor_zero_position(pos0), .resistor_one_position(pos1),
        .resistors_connected(connected), .alarm_interrupt(irq));

    conv_front_model conv_u (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done), .conv_code(conv_code),
        .slow(slow), .codes(codes));

    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No wait states expected; only the watchdog ends a hang
        while (pready !== 1'b1)
        begin
            n++;
            @(posedge pclk);
        end
        chk("pready wait cycles", 32'h0, 32'(n));
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk($sformatf("write error %h", a), {31'h0, ee}, {31'h0, e});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                          input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk($sformatf("reg %h", a), x, q & m);
        chk($sformatf("read error %h", a), {31'h0, ee}, {31'h0, e});
    endtask

    // Clears done flags, then polls until every channel converted again
    task automatic wait_frame();
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        q = 32'h0;
        wr(`OFS_DONE_FLAGS, 32'hF, 1'b0);
        while (q[3:0] !== 4'hF && n < 100)
        begin
            apb(1'b0, `OFS_DONE_FLAGS, 32'h0, q, e);
            n++;
        end
        chk("done flags", 32'hF, q & 32'hF);
    endtask

    always @(posedge pclk or negedge presetn)
        if (!presetn)
            exp_ch <= 2'h0;
        else if (conv_start === 1'b1)
        begin
            chk("conv_channel", {30'h0, exp_ch}, {30'h0, conv_channel});
            exp_ch <= exp_ch + 2'h1;
        end

    // ==========================================
    // Scenarios
    task automatic t_reset();
        chk("resistors_connected", 32'h0, {31'h0, connected});
        rd_chk(`OFS_CONTROL, 32'hFFFF, 32'h1, 1'b0);
        rd_chk(`OFS_HIGH_BASE + 12'h00C, 32'hFFFF, 32'hFFFF, 1'b0);
        rd_chk(`OFS_LOW_BASE + 12'h00C, 32'hFFFF, 32'h0, 1'b0);
        rd_chk(12'h0FC, 32'hFFFFFFFF, 32'h0, 1'b1);
        rd_chk(12'h220, 32'hFFFFFFFF, 32'h0, 1'b1);
    endtask

    task automatic t_pins();
        for (int k = 0; k < 4; k++)
        begin
            in_a <= k[0];
            in_b <= k[1];
            repeat (4) @(posedge pclk);
            chk("buffer_a_output_oe", 32'(!k[0]), {31'h0, oe_a});
            chk("buffer_b_output_oe", 32'(!k[1]), {31'h0, oe_b});
        end
        dis <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("resistors_connected", 32'h1, {31'h0, connected});
        rd_chk(`OFS_STATUS, 32'h8, 32'h0, 1'b0);
        dis <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("resistors_connected", 32'h0, {31'h0, connected});
        rd_chk(`OFS_STATUS, 32'h8, 32'h8, 1'b0);
        dis <= 1'b0;
    endtask

    task automatic t_protect();
        wr(`OFS_CONTROL, 32'h3, 1'b0);
        rd_chk(`OFS_STATUS, 32'h2, 32'h2, 1'b0);
        wr(`OFS_INT_ENABLE, 32'h5, 1'b1);
        rd_chk(`OFS_INT_ENABLE, 32'hF, 32'h0, 1'b0);
        wp <= 1'b0;
        repeat (4) @(posedge pclk);
        rd_chk(`OFS_STATUS, 32'h2, 32'h0, 1'b0);
        wr(`OFS_INT_ENABLE, 32'h5, 1'b0);
        rd_chk(`OFS_INT_ENABLE, 32'hF, 32'h5, 1'b0);
        wr(`OFS_INT_ENABLE, 32'h0, 1'b0);
        wr(`OFS_CONTROL, 32'h1, 1'b0);
    endtask

    task automatic t_results();
        logic [47:0] sets[2] = '{{12'h123, 12'h000, 12'hFFF, 12'h7FF},
                                 {12'hABC, 12'hFFF, 12'h001, 12'h800}};
        for (int s = 0; s < 2; s++)
        begin
            slow <= 1'(s);
            codes <= sets[s];
            wait_frame();
            for (int c = 0; c < 4; c++)
                rd_chk(`OFS_RESULT_BASE + 12'(4*c), 32'hFFFF, {16'h0, sets[s][c*12 +: 12], 4'h0},
                       1'b0);
        end
    endtask

    function automatic int lut_idx(input int deg);
        int i;
        i = (deg + 40) / 2;
        if (i < 0)
            i = 0;
        if (i > 71)
            i = 71;
        return i;
    endfunction

    task automatic t_table();
        int degs[5] = '{20, -50, 110, -39, 101};
        int x;
        for (int i = 0; i < 72; i++)
            wr(`OFS_LUT_BASE + 12'(4*i), {16'h0, 8'(255-i), 8'(i)}, 1'b0);
        wr(`OFS_CONTROL, 32'h0, 1'b0);
        wr(`OFS_MANUAL_POS, 32'h3C96, 1'b0);
        repeat (4) @(posedge pclk);
        chk("resistor_zero_position", 32'h96, {24'h0, pos0});
        chk("resistor_one_position", 32'h3C, {24'h0, pos1});
        wr(`OFS_CONTROL, 32'h1, 1'b0);
        for (int k = 0; k < 5; k++)
        begin
            codes[11:0] <= {8'(degs[k]), 4'h0};
            wait_frame();
            repeat (4) @(posedge pclk);
            x = lut_idx(degs[k]);
            chk("resistor_zero_position", 32'(x), {24'h0, pos0});
            chk("resistor_one_position", 32'(255 - x), {24'h0, pos1});
        end
    endtask

    // Temperature limits chosen so an unsigned compare gives the opposite flags
    task automatic t_alarm();
        slow <= 1'b1;
        codes <= {12'hC00, 12'h400, 12'h800, 12'hF60};
        wr(`OFS_HIGH_BASE, 32'h0A00, 1'b0);
        wr(`OFS_LOW_BASE, 32'h0500, 1'b0);
        wr(`OFS_HIGH_BASE + 12'h004, 32'h7000, 1'b0);
        wr(`OFS_LOW_BASE + 12'h008, 32'h5000, 1'b0);
        wait_frame();
        wr(`OFS_ALARM_HIGH, 32'hF, 1'b0);
        wr(`OFS_ALARM_LOW, 32'hF, 1'b0);
        wait_frame();
        rd_chk(`OFS_ALARM_HIGH, 32'hF, 32'h2, 1'b0);
        rd_chk(`OFS_ALARM_LOW, 32'hF, 32'h5, 1'b0);
        wr(`OFS_INT_ENABLE, 32'h8, 1'b0);
        repeat (2) @(posedge pclk);
        chk("alarm_interrupt", 32'h0, {31'h0, irq});
        wr(`OFS_INT_ENABLE, 32'h2, 1'b0);
        repeat (2) @(posedge pclk);
        chk("alarm_interrupt", 32'h1, {31'h0, irq});
        wr(`OFS_CONTROL, 32'h5, 1'b0);
        repeat (2) @(posedge pclk);
        chk("buffer_a_output_oe", 32'h1, {31'h0, oe_a});
        wr(`OFS_CONTROL, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        chk("buffer_a_output_oe", 32'h0, {31'h0, oe_a});
        wr(`OFS_HIGH_BASE, 32'hFFFF, 1'b0);
        wr(`OFS_LOW_BASE, 32'h8000, 1'b0);
        wr(`OFS_HIGH_BASE + 12'h004, 32'hFFFF, 1'b0);
        wr(`OFS_LOW_BASE + 12'h008, 32'h0, 1'b0);
        wait_frame();
        rd_chk(`OFS_ALARM_HIGH, 32'hF, 32'h2, 1'b0);
        rd_chk(`OFS_ALARM_LOW, 32'hF, 32'h5, 1'b0);
        wr(`OFS_ALARM_HIGH, 32'hF, 1'b0);
        wr(`OFS_ALARM_LOW, 32'hF, 1'b0);
        rd_chk(`OFS_ALARM_HIGH, 32'hF, 32'h0, 1'b0);
        rd_chk(`OFS_ALARM_LOW, 32'hF, 32'h0, 1'b0);
        chk("alarm_interrupt", 32'h0, {31'h0, irq});
    endtask

    // ==========================================
    // Sequence and verdict
    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_pins();
        t_protect();
        t_results();
        t_table();
        t_alarm();
        test_done();
    end

    initial
    begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        test_done();
    end
endmodule

`default_nettype wire
